// ### hw/sspc_pkg.sv
// Package: register map, field positions and modes of the serial port control bank
package sspc_pkg;
    localparam logic [2:0] ADDR_STATUS   = 3'h0;
    localparam logic [2:0] ADDR_CTRL_ONE = 3'h1;
    localparam logic [2:0] ADDR_CTRL_TWO = 3'h2;
    localparam logic [2:0] ADDR_BUFFER   = 3'h3;
    localparam logic [2:0] ADDR_ADDRDIV  = 3'h4;
    localparam logic [7:0] RESET_BYTE    = 8'h00;
    localparam logic [7:0] GEN_CALL_ADDR = 8'h00;
    localparam logic [7:0] BRG_MIN_I2C   = 8'h03;
    localparam logic [7:0] BRG_MIN_SPI   = 8'h01;
    localparam logic [7:0] SPI_DIV4      = 8'h00;
    localparam logic [7:0] SPI_DIV16     = 8'h06;
    localparam logic [7:0] SPI_DIV64     = 8'h1E;
    localparam logic [2:0] BIT_LAST      = 3'h7;

    typedef enum logic [3:0] {
        MODE_SPI_M4    = 4'h0,
        MODE_SPI_M16   = 4'h1,
        MODE_SPI_M64   = 4'h2,
        MODE_SPI_S_SEL = 4'h4,
        MODE_SPI_S     = 4'h5,
        MODE_I2C_S7    = 4'h6,
        MODE_I2C_S10   = 4'h7,
        MODE_I2C_M     = 4'h8,
        MODE_SPI_MDIV  = 4'hA,
        MODE_I2C_FW    = 4'hB,
        MODE_I2C_S7I   = 4'hE,
        MODE_I2C_S10I  = 4'hF
    } sspc_mode_t;

    typedef struct packed {
        logic sample_phase;
        logic clock_edge;
        logic data_address_flag;
        logic stop_seen_flag;
        logic start_seen_flag;
        logic read_write_flag;
        logic update_address_flag;
        logic buffer_full_flag;
    } sspc_status_t;

    typedef struct packed {
        logic       write_collision_flag;
        logic       receive_overflow_flag;
        logic       port_enable;
        logic       clock_polarity_hold;
        logic [3:0] port_mode_field;
    } sspc_ctrl_one_t;

    typedef struct packed {
        logic general_call_enable;
        logic ack_received_status;
        logic ack_value_to_send;
        logic ack_sequence_request;
        logic receive_request;
        logic stop_request;
        logic restart_request;
        logic start_request_stretch_enable;
    } sspc_ctrl_two_t;

    typedef struct packed {
        logic clk;
        logic data;
        logic sel_b;
    } sspc_pins_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_XFER,
        ST_ACK,
        ST_COND
    } sspc_state_t;
endpackage : sspc_pkg

// ### hw/sspc_ctrl.sv
// Serial port control bank with a byte engine for SPI and I2C roles
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ns

// What this block does
// - SPI master samples at end of output time when sample phase set, else middle.
// - In I2C, sample phase set disables slew control, clear enables it.
// - SPI slave: clock edge set shifts out on active-to-idle, clear on idle-to-active; master always on active-to-idle.
// - I2C slave data/address flag shows whether last byte was data or address.
// - Stop and start flags show last condition seen; cleared when port disabled.
// - I2C slave read/write flag holds matched address direction until the next start or stop.
// - I2C master read/write flag shows transmit; OR with requests gives busy.
// - 10-bit slave sets update-address flag when address register needs reload.
// - Buffer full sets on received byte; in I2C transmit stays set while sending.
// - Write collision sets on buffer write when transfer cannot start; software clears.
// - SPI slave overflow sets when byte arrives unread, new byte dropped.
// - I2C slave overflow sets when byte received while buffer still full.
// - Port enable hands serial pins to the port, clear returns them.
// - Clock polarity gives SPI idle level; in I2C slave zero stretches clock.
// - Mode field selects SPI master rates, divider rate, and SPI slave options.
// - Mode field selects I2C slave, master, firmware master; some codes reserved.
// - I2C slave with general call enabled raises interrupt on all-zero address.
// - Ack request drives ack value then self-clears; ack status shows no ack.
// - Start, restart, stop requests make conditions and self-clear; receive takes one byte.
// - In I2C slave the start request bit enables clock stretching.
// - While busy, request bit sets are ignored and buffer writes blocked.
// - 7-bit slave compares address register bits 7 to 1; bit 0 ignored.
module sspc_ctrl (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst_b,
    // Register port
    input  wire logic [2:0]       reg_addr,
    input  wire logic [7:0]       reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic      [7:0]       reg_rdata,
    // Serial pins, each as input, output and enable
    input  wire sspc_pkg::sspc_pins_t pin_in,
    output sspc_pkg::sspc_pins_t  pin_out,
    output sspc_pkg::sspc_pins_t  pin_oe,
    // Port ownership, slew control and event
    output logic                  pins_owned,
    output logic                  slew_limit,
    output logic                  port_event
);

    typedef struct packed {
        sspc_pkg::sspc_status_t   st;
        sspc_pkg::sspc_ctrl_one_t c1;
        sspc_pkg::sspc_ctrl_two_t c2;
        sspc_pkg::sspc_state_t    fsm;
        logic [7:0] buf_q;
        logic [7:0] addr_div;
        logic [7:0] shreg;
        logic [7:0] brg;
        logic [2:0] bitcnt;
        logic       sclk;
        logic       dout;
        logic       half;
        logic       rx_mode;
        logic       addr_byte;
        logic       addr_hi;
        logic [7:0] rdata;
        logic       event_q;
        sspc_pkg::sspc_pins_t s1;
        sspc_pkg::sspc_pins_t s2;
        sspc_pkg::sspc_pins_t s3;
    } sspc_state_all_t;

    sspc_state_all_t s_r;
    sspc_state_all_t s_nxt;

    // ----------------------------------------------------------------
    // Mode decode
    // ----------------------------------------------------------------
    logic [3:0] mode;
    logic       is_spi_m;
    logic       is_spi_s;
    logic       is_i2c_m;
    logic       is_i2c_s;
    logic       is_10b;
    logic       i2c_busy;
    logic       clk_rise;
    logic       clk_fall;
    logic       sda_rise;
    logic       sda_fall;
    logic       brg_tick;
    logic       shift_edge;
    logic       samp_edge;
    logic       spi_sel_ok;
    logic [7:0] reload;
    logic [7:0] rx_byte;

    assign mode     = s_r.c1.port_mode_field;
    assign is_spi_m = (mode == sspc_pkg::MODE_SPI_M4) || (mode == sspc_pkg::MODE_SPI_M16)
                   || (mode == sspc_pkg::MODE_SPI_M64) || (mode == sspc_pkg::MODE_SPI_MDIV);
    assign is_spi_s = (mode == sspc_pkg::MODE_SPI_S_SEL) || (mode == sspc_pkg::MODE_SPI_S);
    assign is_i2c_m = (mode == sspc_pkg::MODE_I2C_M) || (mode == sspc_pkg::MODE_I2C_FW);
    assign is_i2c_s = (mode == sspc_pkg::MODE_I2C_S7) || (mode == sspc_pkg::MODE_I2C_S10)
                   || (mode == sspc_pkg::MODE_I2C_S7I) || (mode == sspc_pkg::MODE_I2C_S10I);
    assign is_10b   = (mode == sspc_pkg::MODE_I2C_S10) || (mode == sspc_pkg::MODE_I2C_S10I);
    assign i2c_busy = s_r.st.read_write_flag | s_r.c2.ack_sequence_request
                    | s_r.c2.receive_request | s_r.c2.stop_request | s_r.c2.restart_request
                    | s_r.c2.start_request_stretch_enable;

    // Only s2 and s3 are read, s1 feeds s2 alone
    assign clk_rise = s_r.s2.clk & ~s_r.s3.clk;
    assign clk_fall = ~s_r.s2.clk & s_r.s3.clk;
    assign sda_rise = s_r.s2.data & ~s_r.s3.data;
    assign sda_fall = ~s_r.s2.data & s_r.s3.data;
    assign spi_sel_ok = (mode != sspc_pkg::MODE_SPI_S_SEL) | ~s_r.s2.sel_b;

    always_comb
    begin
        case (mode)
            sspc_pkg::MODE_SPI_M4:  reload = sspc_pkg::SPI_DIV4;
            sspc_pkg::MODE_SPI_M16: reload = sspc_pkg::SPI_DIV16;
            sspc_pkg::MODE_SPI_M64: reload = sspc_pkg::SPI_DIV64;
            default:                reload = s_r.addr_div;
        endcase
    end
    assign brg_tick = (s_r.brg == sspc_pkg::RESET_BYTE);

    // Slave edges: polarity and clock edge together pick the shifting edge
    assign shift_edge = (s_r.c1.clock_polarity_hold ^ s_r.st.clock_edge) ? clk_fall : clk_rise;
    assign samp_edge  = (s_r.c1.clock_polarity_hold ^ s_r.st.clock_edge) ? clk_rise : clk_fall;

    assign rx_byte = {s_r.shreg[6:0], s_r.s2.data};

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        s_nxt         = s_r;
        s_nxt.s1      = pin_in;
        s_nxt.s2      = s_r.s1;
        s_nxt.s3      = s_r.s2;
        s_nxt.event_q = 1'b0;
        s_nxt.rdata   = sspc_pkg::RESET_BYTE;

        // Register reads
        if (reg_rd)
        begin
            case (reg_addr)
                sspc_pkg::ADDR_STATUS:   s_nxt.rdata = s_r.st;
                sspc_pkg::ADDR_CTRL_ONE: s_nxt.rdata = s_r.c1;
                sspc_pkg::ADDR_CTRL_TWO: s_nxt.rdata = s_r.c2;
                sspc_pkg::ADDR_BUFFER:   s_nxt.rdata = s_r.buf_q;
                sspc_pkg::ADDR_ADDRDIV:  s_nxt.rdata = s_r.addr_div;
                default:                 s_nxt.rdata = sspc_pkg::RESET_BYTE;
            endcase
            if (reg_addr == sspc_pkg::ADDR_BUFFER)
            begin
                s_nxt.st.buffer_full_flag = 1'b0;
            end
        end

        // Register writes; flags set by hardware later override clears
        if (reg_wr)
        begin
            case (reg_addr)
                sspc_pkg::ADDR_STATUS:
                begin
                    s_nxt.st.sample_phase = reg_wdata[7];
                    s_nxt.st.clock_edge   = reg_wdata[6];
                end
                sspc_pkg::ADDR_CTRL_ONE:
                begin
                    s_nxt.c1.write_collision_flag  = s_r.c1.write_collision_flag & reg_wdata[7];
                    s_nxt.c1.receive_overflow_flag = s_r.c1.receive_overflow_flag & reg_wdata[6];
                    s_nxt.c1.port_enable           = reg_wdata[5];
                    s_nxt.c1.clock_polarity_hold   = reg_wdata[4];
                    s_nxt.c1.port_mode_field       = reg_wdata[3:0];
                end
                sspc_pkg::ADDR_CTRL_TWO:
                begin
                    s_nxt.c2.general_call_enable = reg_wdata[7];
                    s_nxt.c2.ack_value_to_send   = reg_wdata[5];
                    if (is_i2c_m)
                    begin
                        // Requests are not queued while busy
                        if (!i2c_busy)
                        begin
                            s_nxt.c2.ack_sequence_request = reg_wdata[4];
                            s_nxt.c2.receive_request      = reg_wdata[3];
                            s_nxt.c2.stop_request         = reg_wdata[2];
                            s_nxt.c2.restart_request      = reg_wdata[1];
                            s_nxt.c2.start_request_stretch_enable = reg_wdata[0];
                        end
                    end
                    else
                    begin
                        s_nxt.c2.start_request_stretch_enable = reg_wdata[0];
                    end
                end
                sspc_pkg::ADDR_BUFFER:
                begin
                    if ((is_i2c_m && i2c_busy) || (s_r.fsm != sspc_pkg::ST_IDLE))
                    begin
                        s_nxt.c1.write_collision_flag = 1'b1;
                    end
                    else
                    begin
                        s_nxt.buf_q   = reg_wdata;
                        s_nxt.shreg   = reg_wdata;
                        s_nxt.bitcnt  = sspc_pkg::BIT_LAST;
                        s_nxt.rx_mode = 1'b0;
                        s_nxt.dout    = reg_wdata[7];
                        if (is_spi_m || is_i2c_m)
                        begin
                            s_nxt.fsm  = sspc_pkg::ST_XFER;
                            s_nxt.brg  = reload;
                            s_nxt.half = 1'b0;
                        end
                        if (is_i2c_m)
                        begin
                            s_nxt.st.read_write_flag  = 1'b1;
                            s_nxt.st.buffer_full_flag = 1'b1;
                        end
                    end
                end
                sspc_pkg::ADDR_ADDRDIV:
                begin
                    s_nxt.addr_div = reg_wdata;
                    s_nxt.st.update_address_flag = 1'b0;
                end
                default:
                begin
                end
            endcase
        end

        // Byte engine
        if (!s_r.c1.port_enable)
        begin
            s_nxt.st.stop_seen_flag  = 1'b0;
            s_nxt.st.start_seen_flag = 1'b0;
            s_nxt.fsm                = sspc_pkg::ST_IDLE;
            s_nxt.sclk               = s_r.c1.clock_polarity_hold;
            // Data line released, so a later start shows as a falling edge
            s_nxt.dout               = 1'b1;
        end
        else if (is_spi_m)
        begin
            if (s_r.fsm == sspc_pkg::ST_XFER)
            begin
                s_nxt.brg = brg_tick ? reload : s_r.brg - 8'h01;
                if (brg_tick)
                begin
                    s_nxt.half = ~s_r.half;
                    s_nxt.sclk = ~s_r.sclk;
                    if (!s_r.half)
                    begin
                        if (!s_r.st.sample_phase)
                        begin
                            s_nxt.shreg = rx_byte;
                        end
                    end
                    else
                    begin
                        if (s_r.st.sample_phase)
                        begin
                            s_nxt.shreg = rx_byte;
                        end
                        s_nxt.dout   = s_nxt.shreg[7];
                        s_nxt.bitcnt = s_r.bitcnt - 3'h1;
                        if (s_r.bitcnt == 3'h0)
                        begin
                            // Master never overflows
                            s_nxt.fsm                 = sspc_pkg::ST_IDLE;
                            s_nxt.buf_q               = s_nxt.shreg;
                            s_nxt.st.buffer_full_flag = 1'b1;
                            s_nxt.event_q             = 1'b1;
                        end
                    end
                end
            end
        end
        else if (is_spi_s && spi_sel_ok)
        begin
            // Sample on the edge opposite the shifting edge
            if (samp_edge)
            begin
                s_nxt.shreg  = rx_byte;
                s_nxt.bitcnt = s_r.bitcnt - 3'h1;
                if (s_r.bitcnt == 3'h0)
                begin
                    if (s_r.st.buffer_full_flag)
                    begin
                        s_nxt.c1.receive_overflow_flag = 1'b1;
                    end
                    else
                    begin
                        s_nxt.buf_q               = rx_byte;
                        s_nxt.st.buffer_full_flag = 1'b1;
                    end
                    s_nxt.event_q = 1'b1;
                end
            end
            else if (shift_edge)
            begin
                s_nxt.dout = s_r.shreg[7];
            end
        end
        else if (is_i2c_s || is_i2c_m)
        begin
            // Conditions seen on the bus while the clock is high
            if (s_r.s2.clk && s_r.s3.clk && sda_fall)
            begin
                s_nxt.st.start_seen_flag = 1'b1;
                s_nxt.st.stop_seen_flag  = 1'b0;
                s_nxt.bitcnt             = sspc_pkg::BIT_LAST;
                s_nxt.addr_byte          = 1'b1;
                if (is_i2c_s)
                begin
                    s_nxt.st.read_write_flag = 1'b0;
                end
            end
            if (s_r.s2.clk && s_r.s3.clk && sda_rise)
            begin
                s_nxt.st.stop_seen_flag  = 1'b1;
                s_nxt.st.start_seen_flag = 1'b0;
                if (is_i2c_s)
                begin
                    s_nxt.st.read_write_flag = 1'b0;
                end
            end
            if (is_i2c_s && clk_rise && s_r.fsm != sspc_pkg::ST_ACK)
            begin
                s_nxt.shreg  = rx_byte;
                s_nxt.bitcnt = s_r.bitcnt - 3'h1;
                if (s_r.bitcnt == 3'h0)
                begin
                    s_nxt.fsm = sspc_pkg::ST_ACK;
                    if (s_r.st.buffer_full_flag)
                    begin
                        s_nxt.c1.receive_overflow_flag = 1'b1;
                    end
                    else
                    begin
                        s_nxt.buf_q               = rx_byte;
                        s_nxt.st.buffer_full_flag = 1'b1;
                    end
                    s_nxt.st.data_address_flag = ~s_r.addr_byte;
                    s_nxt.addr_byte            = 1'b0;
                    s_nxt.event_q              = 1'b1;
                    if (s_r.addr_byte)
                    begin
                        if (rx_byte[7:1] == s_r.addr_div[7:1])
                        begin
                            s_nxt.st.read_write_flag = rx_byte[0];
                        end
                        if (is_10b)
                        begin
                            s_nxt.st.update_address_flag = 1'b1;
                        end
                        if (s_r.c2.general_call_enable && rx_byte == sspc_pkg::GEN_CALL_ADDR)
                        begin
                            s_nxt.event_q = 1'b1;
                        end
                    end
                    if (s_r.c2.start_request_stretch_enable)
                    begin
                        s_nxt.c1.clock_polarity_hold = 1'b0;
                    end
                end
            end
            else if (is_i2c_s && clk_fall && s_r.fsm == sspc_pkg::ST_ACK)
            begin
                s_nxt.fsm = sspc_pkg::ST_IDLE;
            end
            if (is_i2c_m)
            begin
                // Held at reload while idle, so every sequence gets a full period
                s_nxt.brg = (brg_tick || !i2c_busy) ? reload : s_r.brg - 8'h01;
                if (brg_tick)
                begin
                    if (s_r.c2.start_request_stretch_enable || s_r.c2.restart_request)
                    begin
                        s_nxt.dout = 1'b0;
                        s_nxt.c2.start_request_stretch_enable = 1'b0;
                        s_nxt.c2.restart_request = 1'b0;
                    end
                    else if (s_r.c2.stop_request)
                    begin
                        s_nxt.dout            = 1'b1;
                        s_nxt.sclk            = 1'b1;
                        s_nxt.c2.stop_request = 1'b0;
                    end
                    else if (s_r.c2.ack_sequence_request)
                    begin
                        s_nxt.dout = s_r.c2.ack_value_to_send;
                        s_nxt.c2.ack_sequence_request = 1'b0;
                    end
                    else if (s_r.fsm == sspc_pkg::ST_XFER || s_r.c2.receive_request)
                    begin
                        s_nxt.sclk = ~s_r.sclk;
                        if (!s_r.sclk)
                        begin
                            s_nxt.shreg  = rx_byte;
                            s_nxt.bitcnt = s_r.bitcnt - 3'h1;
                            s_nxt.dout   = s_r.c2.receive_request ? 1'b1 : s_r.shreg[6];
                            if (s_r.bitcnt == 3'h0)
                            begin
                                s_nxt.fsm                = sspc_pkg::ST_IDLE;
                                s_nxt.st.read_write_flag = 1'b0;
                                s_nxt.st.buffer_full_flag = s_r.c2.receive_request;
                                s_nxt.c2.receive_request = 1'b0;
                                s_nxt.c2.ack_received_status = s_r.s2.data;
                                s_nxt.event_q            = 1'b1;
                                if (s_r.c2.receive_request)
                                begin
                                    s_nxt.buf_q = rx_byte;
                                end
                            end
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    logic i2c_on;
    assign i2c_on     = s_r.c1.port_enable & (is_i2c_s | is_i2c_m);
    assign reg_rdata  = s_r.rdata;
    assign pins_owned = s_r.c1.port_enable;
    assign slew_limit = i2c_on & ~s_r.st.sample_phase;
    assign port_event = s_r.event_q;
    // Open drain on I2C: only drive low; clock held low while stretching
    assign pin_out.clk   = i2c_on ? 1'b0 : s_r.sclk;
    assign pin_out.data  = i2c_on ? 1'b0 : s_r.dout;
    assign pin_out.sel_b = 1'b1;
    assign pin_oe.clk    = s_r.c1.port_enable & (i2c_on ? ((is_i2c_m & ~s_r.sclk)
                         | (is_i2c_s & ~s_r.c1.clock_polarity_hold)) : is_spi_m);
    assign pin_oe.data   = s_r.c1.port_enable & (i2c_on ? (is_i2c_m & ~s_r.dout)
                         : (is_spi_m | (is_spi_s & spi_sel_ok)));
    assign pin_oe.sel_b  = 1'b0;

endmodule : sspc_ctrl

// ### test/sspc_far.sv
// Far-side model: SPI slave with a fixed byte, pull-ups on I2C lines
`timescale 1ns/1ns
module sspc_far (
    input logic                 spi,
    input sspc_pkg::sspc_pins_t pin_out,
    input sspc_pkg::sspc_pins_t pin_oe,
    output sspc_pkg::sspc_pins_t pin_in
);
    logic [7:0] sr_r = 8'hA5;
    // Shift on the fall so data settles before the sampling rise
    // Reloaded while the lines serve I2C, so each SPI phase starts alike
    always @(negedge pin_out.clk or negedge spi)
        if (!spi)
            sr_r <= 8'hA5;
        else
            sr_r <= {sr_r[6:0], sr_r[7]};
    // Released open-drain lines read high
    assign pin_in = {spi ? pin_out.clk : !(pin_oe.clk && !pin_out.clk),
                     spi ? sr_r[7] : !(pin_oe.data && !pin_out.data), 1'b0};
endmodule : sspc_far

// ### test/sspc_chk_properties.sv
// Checker of the register port, pin ownership and slew
`timescale 1ns/1ns
module sspc_chk (
    input logic                 clock,
    input logic                 rst_b,
    input logic [2:0]           reg_addr,
    input logic [7:0]           reg_wdata,
    input logic                 reg_wr,
    input logic                 reg_rd,
    input logic [7:0]           reg_rdata,
    input sspc_pkg::sspc_pins_t pin_oe,
    input logic                 pins_owned,
    input logic                 slew_limit
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    property p_own; reg_wr && reg_addr == 3'h1 |=> pins_owned == $past(reg_wdata[5]); endproperty
    a_own: assert property (p_own) else $error("pins_owned");
    property p_oe; !pins_owned [*3] |-> pin_oe == '0; endproperty
    a_oe: assert property (p_oe) else $error("pin_oe");
    property p_mode; reg_rd && reg_addr == 3'h1 && $past(reg_wr && reg_addr == 3'h1, 2)
        |=> reg_rdata[5:0] == $past(reg_wdata[5:0], 3); endproperty
    a_mode: assert property (p_mode) else $error("mode");
    property p_phase; reg_rd && reg_addr == 3'h0 && $past(reg_wr && reg_addr == 3'h0, 2)
        |=> reg_rdata[7:6] == $past(reg_wdata[7:6], 3); endproperty
    a_phase: assert property (p_phase) else $error("phase");
    property p_gcall; reg_rd && reg_addr == 3'h2 && $past(reg_wr && reg_addr == 3'h2, 2)
        |=> reg_rdata[7] == $past(reg_wdata[7], 3); endproperty
    a_gcall: assert property (p_gcall) else $error("gcall");
    property p_ack_value_to_send; $past(reg_wr && reg_addr == 3'h2 && reg_wdata[5], 2) && reg_rd
        && reg_addr == 3'h2 |=> reg_rdata[5]; endproperty
    a_ack_value_to_send: assert property (p_ack_value_to_send) else $error("ack_value_to_send");
    property p_seen; reg_rd && reg_addr == 3'h0 && !pins_owned |=> reg_rdata[4:3] == 2'b00; endproperty
    a_seen: assert property (p_seen) else $error("seen");
    property p_slew; reg_wr && reg_addr == 3'h0 && reg_wdata[7] |-> ##[1:2] !slew_limit; endproperty
    a_slew: assert property (p_slew) else $error("slew");
endmodule : sspc_chk
bind sspc_ctrl sspc_chk u_chk (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin_oe(pin_oe), .pins_owned(pins_owned), .slew_limit(slew_limit));

// ### test/sspc_ctrl_tb.sv
// Self-checking bench of the serial port control bank
`timescale 1ns/1ns
module sspc_ctrl_tb;
    logic clock = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, spi = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, d, v;
    logic pins_owned, slew_limit, port_event;
    sspc_pkg::sspc_pins_t pin_in, pin_out, pin_oe;
    int fails = 0, comparisons = 0;
    always #5 clock = ~clock;
    sspc_ctrl u_dut (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pins_owned(pins_owned),
        .slew_limit(slew_limit), .port_event(port_event));
    sspc_far u_far (.spi(spi), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        comparisons++;
        if (s !== e)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] x);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= x;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        d = reg_rdata;
        chk("reg_rdata", e & m, d & m);
    endtask : rd
    task automatic print_verdict;
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    // Hang guard, far beyond the several hundred cycles the run needs
    initial
    begin
        #300000;
        fails++;
        print_verdict();
    end
    initial
    begin
        void'($urandom(32'h8EBF9EE2));
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        for (int a = 0; a < 3; a++) rd(3'(a), 8'h00, 8'hFF);
        for (int i = 0; i < 12; i++)
        begin
            v = {2'b00, 2'($urandom), 4'(48'h0124_5678_ABEF >> (4 * i))};
            wr(3'h1, v);
            rd(3'h1, v, 8'hFF);
            chk("pins_owned", {7'h00, v[5]}, {7'h00, pins_owned});
        end
        wr(3'h2, 8'hA0);
        rd(3'h2, 8'hA0, 8'hE0);
        spi = 1'b0;
        wr(3'h1, 8'h18);
        wr(3'h1, 8'h38);
        wr(3'h0, 8'h00);
        repeat (2) @(negedge clock);
        chk("slew_limit", 8'h01, {7'h00, slew_limit});
        wr(3'h0, 8'h80);
        rd(3'h0, 8'h80, 8'hC0);
        wr(3'h4, 8'h09);
        // Each request is followed by a stop that must be dropped while busy
        for (int i = 0; i < 2; i++)
        begin
            v = i ? 8'h04 : 8'h01;
            wr(3'h2, v);
            wr(3'h2, v | 8'h04);
            d = 8'h07;
            for (int k = 0; k < 300 && (d & 8'h07) !== 8'h00; k++) rd(3'h2, 8'h00, 8'h00);
            chk("request", 8'h00, d & 8'h07);
            rd(3'h0, i ? 8'h10 : 8'h08, 8'h18);
        end
        wr(3'h1, 8'h08);
        rd(3'h0, 8'h00, 8'h18);
        spi = 1'b1;
        wr(3'h1, 8'h22);
        wr(3'h0, 8'h40);
        v = 8'($urandom);
        wr(3'h3, v);
        wr(3'h3, ~v);
        for (int k = 0; k < 3000 && port_event !== 1'b1; k++) @(negedge clock);
        chk("port_event", 8'h01, {7'h00, port_event});
        rd(3'h0, 8'h41, 8'hC1);
        rd(3'h3, 8'hA5, 8'hFF);
        rd(3'h0, 8'h00, 8'h01);
        rd(3'h1, 8'hA2, 8'hFF);
        wr(3'h1, 8'h22);
        rd(3'h1, 8'h22, 8'hFF);
        print_verdict();
    end
endmodule : sspc_ctrl_tb
